// ===== logic/tag_seq_pkg.sv
package tag_seq_pkg;
	// APB register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] PERIOD_OFS = 8'h04;
	localparam logic [7:0] ANT_LIST_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	localparam logic [7:0] RESP_OFS = 8'h10;
	// Control register fields, limits and reset values
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int CTRL_MODE_LSB = 4;
	localparam int CTRL_CNT_LSB = 8;
	localparam logic [3:0] ANT_COUNT_MAX = 4'h9;
	localparam logic [2:0] ANT_PORT_MIN = 3'h1;
	localparam logic [2:0] ANT_PORT_MAX = 3'h4;
	localparam logic [31:0] PERIOD_RESET = 32'h0000_0000;
	localparam logic [7:0] TAG_CNT_ZERO = 8'h00;
	// Status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_BADCMD_BIT = 1;
	localparam int STAT_RESPV_BIT = 2;
	localparam int STAT_ANT_LSB = 4;
	localparam int STAT_STATE_LSB = 8;
	typedef enum logic [1:0] {
		MODE_SINGLE_ONCE,
		MODE_SINGLE_REPEAT,
		MODE_MULTI_ONCE,
		MODE_MULTI_REPEAT
	} seq_mode_t;
endpackage

// ===== logic/resp_fifo.sv
`timescale 1ns/1ps
module resp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;
	assign in_ready = count_reg != (AW+1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge pclk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // resp_fifo

// ===== logic/tag_access_sequencer.sv
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module tag_access_sequencer
	import tag_seq_pkg::*;
#(
	parameter int TAG_W = 16,
	parameter int RESP_DEPTH = 8,
	parameter int MAX_TAGS = 8
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [2:0] ant_sel,
	output logic search_req,
	output logic search_one,
	input wire logic search_done,
	input wire logic tag_valid,
	input wire logic [TAG_W-1:0] tag_id
);
	import tag_seq_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_SEARCH, ST_WAIT, ST_REPORT, ST_PUSH} state_t;

	function automatic logic ant_ok(input logic [2:0] p);
		return p >= ANT_PORT_MIN && p <= ANT_PORT_MAX;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	state_t state_reg;
	seq_mode_t mode_reg;
	logic [3:0] ant_cnt_reg;
	logic [3:0] ant_idx_reg;
	logic [35:0] ant_list_reg;
	logic [31:0] period_reg;
	logic [31:0] timer_reg;
	logic stop_reg;
	logic bad_cmd_reg;
	logic [7:0] tag_cnt_reg;
	logic [TAG_W-1:0] last_tag_reg;
	logic [2:0] ant_sel_reg;
	logic search_req_reg;
	logic [31:0] fifo_in;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [31:0] fifo_out;
	logic fifo_pop;
	logic wr_en;
	logic rd_en;
	logic start_cmd;
	logic cmd_ok;
	logic timed_out;
	logic single_mode;
	logic repeat_mode;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign start_cmd = wr_en && paddr == CTRL_OFS && pwdata[CTRL_START_BIT];
	assign single_mode = mode_reg == MODE_SINGLE_ONCE || mode_reg == MODE_SINGLE_REPEAT;
	assign repeat_mode = mode_reg == MODE_SINGLE_REPEAT || mode_reg == MODE_MULTI_REPEAT;
	assign timed_out = period_reg != '0 && timer_reg >= period_reg;
	assign fifo_pop = rd_en && paddr == RESP_OFS && fifo_out_valid;

	always_comb
	begin
		cmd_ok = pwdata[CTRL_CNT_LSB +: 4] != 4'h0
			&& pwdata[CTRL_CNT_LSB +: 4] <= ANT_COUNT_MAX;
		for (int i = 0; i < 9; i++)
			if (i < int'(pwdata[CTRL_CNT_LSB +: 4]) && !ant_ok(ant_list_reg[i*4 +: 3]))
				cmd_ok = 1'b0;
	end

	// Response word: count in top byte, tag id (last read) below
	assign fifo_in = {tag_cnt_reg, 8'h00, 16'(last_tag_reg)};

	resp_fifo #(.WIDTH(32), .DEPTH(RESP_DEPTH)) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(state_reg == ST_PUSH),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			period_reg <= PERIOD_RESET;
			ant_list_reg <= '0;
		end
		else if (wr_en && state_reg == ST_IDLE)
		begin
			if (paddr == PERIOD_OFS)
				period_reg <= pwdata;
			if (paddr == ANT_LIST_OFS)
				ant_list_reg <= {ant_list_reg[3:0], pwdata[31:0]} & 36'h7_7777_7777;
			if (paddr == ANT_LIST_OFS + 8'h04)
				ant_list_reg[35:32] <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= ST_IDLE;
			mode_reg <= MODE_SINGLE_ONCE;
			ant_cnt_reg <= '0;
			ant_idx_reg <= '0;
			timer_reg <= '0;
			stop_reg <= 1'b0;
			bad_cmd_reg <= 1'b0;
			tag_cnt_reg <= TAG_CNT_ZERO;
			last_tag_reg <= '0;
			ant_sel_reg <= '0;
			search_req_reg <= 1'b0;
		end
		else
		begin
			search_req_reg <= 1'b0;
			if (state_reg != ST_IDLE && wr_en && paddr == CTRL_OFS && pwdata[CTRL_STOP_BIT])
				stop_reg <= 1'b1;
			if (state_reg != ST_IDLE && state_reg != ST_PUSH)
				timer_reg <= timer_reg + 32'h1;
			case (state_reg)
				ST_IDLE:
				begin
					stop_reg <= 1'b0;
					if (start_cmd)
					begin
						bad_cmd_reg <= !cmd_ok;
						if (cmd_ok)
						begin
							mode_reg <= seq_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
							ant_cnt_reg <= pwdata[CTRL_CNT_LSB +: 4];
							ant_idx_reg <= '0;
							timer_reg <= '0;
							tag_cnt_reg <= TAG_CNT_ZERO;
							state_reg <= ST_SEARCH;
						end
					end
				end
				ST_SEARCH:
				begin
					ant_sel_reg <= ant_list_reg[ant_idx_reg*4 +: 3];
					search_req_reg <= 1'b1;
					state_reg <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (search_done)
					begin
						ant_idx_reg <= (ant_idx_reg + 4'h1 == ant_cnt_reg) ? '0 : ant_idx_reg + 4'h1;
						if (tag_valid)
						begin
							last_tag_reg <= tag_id;
							if (tag_cnt_reg != 8'(MAX_TAGS))
								tag_cnt_reg <= tag_cnt_reg + 8'h1;
						end
						if (single_mode && tag_valid)
							state_reg <= ST_PUSH;
						else if (timed_out && (!single_mode || !repeat_mode))
							state_reg <= ST_PUSH;
						else if (stop_reg)
							state_reg <= ST_IDLE;
						else
							state_reg <= ST_SEARCH;
					end
				end
				ST_PUSH:
				begin
					if (fifo_in_ready)
						state_reg <= ST_REPORT;
				end
				ST_REPORT:
				begin
					tag_cnt_reg <= TAG_CNT_ZERO;
					timer_reg <= '0;
					if (repeat_mode && !stop_reg)
						state_reg <= ST_SEARCH;
					else
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign ant_sel = ant_sel_reg;
	assign search_req = search_req_reg;
	// Single modes ask the air side for one tag only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			search_one <= 1'b0;
		else
			search_one <= single_mode;
	end

	////////////////////////////////////////////////////////////////////////////
	// Zero wait states; only addresses above RESP_OFS raise pslverr
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && paddr > RESP_OFS;
			prdata <= '0;
			if (psel && !penable && !pwrite)
				case (paddr)
					CTRL_OFS: prdata <= {20'h0, ant_cnt_reg, 2'h0, mode_reg, 4'h0};
					PERIOD_OFS: prdata <= period_reg;
					ANT_LIST_OFS: prdata <= ant_list_reg[31:0];
					STATUS_OFS: prdata <= {21'h0, state_reg, ant_idx_reg,
						1'b0, fifo_out_valid, bad_cmd_reg, state_reg != ST_IDLE};
					RESP_OFS: prdata <= fifo_out_valid ? fifo_out : 32'h0;
					default: prdata <= 32'h0;
				endcase
		end
	end

	chk_single_one_resp: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_WAIT && search_done && tag_valid && single_mode
		|=> state_reg == ST_PUSH) else $error("single tag not reported");
	chk_stop_idle: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_REPORT && !repeat_mode |=> state_reg == ST_IDLE)
		else $error("once sequence did not end");
	chk_repeat_restart: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_REPORT && repeat_mode && !stop_reg |=> state_reg == ST_SEARCH)
		else $error("repeat did not restart");
	chk_ant_range: assert property (@(posedge pclk) disable iff (!presetn)
		search_req |-> ant_sel >= ANT_PORT_MIN && ant_sel <= ANT_PORT_MAX)
		else $error("antenna out of range");
	chk_ant_count: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg != ST_IDLE |-> ant_idx_reg < ant_cnt_reg && ant_cnt_reg <= ANT_COUNT_MAX)
		else $error("antenna index out of list");
	chk_count_reset: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_REPORT |=> tag_cnt_reg == TAG_CNT_ZERO)
		else $error("tag count not cleared");
	chk_timeout_resp: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_WAIT && search_done && !single_mode && timed_out
		|=> state_reg == ST_PUSH) else $error("period end not reported");
	chk_stop_no_tx: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_WAIT && search_done && stop_reg && !tag_valid && !timed_out
		|=> state_reg == ST_IDLE) else $error("stop did not end sequence");

	////////////////////////////////////////////////////////////////////////////
	// Independent tally of tags read since the last report
	logic [7:0] tags_seen_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tags_seen_reg <= 8'h00;
		else if (state_reg == ST_IDLE || state_reg == ST_REPORT)
			tags_seen_reg <= 8'h00;
		else if (state_reg == ST_WAIT && search_done && tag_valid
			&& tags_seen_reg != 8'(MAX_TAGS))
			tags_seen_reg <= tags_seen_reg + 8'h01;
	end

	chk_tally_match: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_PUSH
		|-> tag_cnt_reg == tags_seen_reg)
		else $error("response count differs from tags read");

	chk_count_cap: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg != ST_IDLE
		|-> tag_cnt_reg <= 8'(MAX_TAGS))
		else $error("tag count above limit");

	chk_push_once: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_PUSH && fifo_in_ready
		|=> state_reg == ST_REPORT)
		else $error("response not pushed");

	chk_search_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		search_req
		|=> !search_req)
		else $error("search request longer than one cycle");

	chk_search_wait: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_SEARCH
		|=> state_reg == ST_WAIT && search_req)
		else $error("search step not issued");

	chk_idle_start: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_IDLE && start_cmd && cmd_ok
		|=> state_reg == ST_SEARCH)
		else $error("valid command not started");

	chk_bad_no_run: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_IDLE && start_cmd && !cmd_ok
		|=> state_reg == ST_IDLE && bad_cmd_reg)
		else $error("bad command started a run");

	chk_single_flag: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_WAIT
		|-> search_one == single_mode)
		else $error("one-tag flag wrong during search");

	chk_srep_no_end: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_WAIT && search_done && !tag_valid
		&& mode_reg == MODE_SINGLE_REPEAT && !stop_reg
		|=> state_reg == ST_SEARCH)
		else $error("single repeat ended without stop");

	chk_so_ends: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_REPORT && mode_reg == MODE_SINGLE_ONCE
		|=> state_reg == ST_IDLE)
		else $error("single once did not end after response");

	// Busy runs must not see their list or period change under them
	chk_list_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg != ST_IDLE
		|=> $stable(ant_list_reg))
		else $error("antenna list changed while busy");

	chk_period_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg != ST_IDLE
		|=> $stable(period_reg))
		else $error("period changed while busy");

	chk_idle_clear: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_IDLE
		|=> !stop_reg)
		else $error("stale stop carried into next command");
endmodule // tag_access_sequencer

// ===== verif/air_side_model.sv
`timescale 1ns/1ps
module air_side_model #(
	parameter logic [15:0] TAG_BASE = 16'h0A00
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic search_req,
	input wire logic present,
	input wire logic [2:0] dly,
	output logic search_done,
	output logic tag_valid,
	output logic [15:0] tag_id,
	output int tags_given
);
	logic [2:0] wait_reg;
	logic busy_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy_reg <= 1'b0;
			wait_reg <= 3'h0;
			search_done <= 1'b0;
			tag_valid <= 1'b0;
			tag_id <= 16'h5A5A;
			tags_given <= 0;
		end
		else
		begin
			search_done <= 1'b0;
			tag_valid <= 1'b0;
			// Idle id lines toggle so a stale id never passes
			tag_id <= ~tag_id;
			if (search_req)
			begin
				busy_reg <= 1'b1;
				wait_reg <= dly;
			end
			else if (busy_reg && wait_reg != 3'h0)
				wait_reg <= wait_reg - 3'h1;
			else if (busy_reg)
			begin
				busy_reg <= 1'b0;
				search_done <= 1'b1;
				if (present)
				begin
					tag_valid <= 1'b1;
					tag_id <= TAG_BASE + tags_given[15:0];
					tags_given <= tags_given + 1;
				end
			end
		end
	end
endmodule // air_side_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import tag_seq_pkg::*;
	localparam logic [15:0] TAG_BASE = 16'h0A00;
	localparam logic [31:0] MASK = 32'hFF00_FFFF;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, present = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r, dt, rng = 32'h0AB4B4C2;
	logic pready, pslverr, search_req, search_one, search_done, tag_valid, e, found;
	logic [2:0] ant_sel, dly = 3'h1;
	logic [15:0] tag_id;
	logic [3:0] ant_q[$];
	int tags_given, t0, k, miscompares = 0, n_compared = 0, n_req = 0;
	bit ant_on = 0;
	tag_access_sequencer u_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ant_sel(ant_sel), .search_req(search_req), .search_one(search_one),
		.search_done(search_done), .tag_valid(tag_valid), .tag_id(tag_id));
	air_side_model #(.TAG_BASE(TAG_BASE)) u_air(.pclk(pclk), .presetn(presetn),
		.search_req(search_req), .present(present), .dly(dly), .search_done(search_done),
		.tag_valid(tag_valid), .tag_id(tag_id), .tags_given(tags_given));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	always #2.5 pclk = ~pclk;
	always @(posedge pclk)
	begin
		rng <= xs(rng);
		dly <= {1'b0, rng[1:0]} + 3'h1;
	end
	task report_and_stop;
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cmp_word(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_compared++;
		if (got !== ex)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task cmp_ant(input logic [3:0] ex, input logic [3:0] got);
		cmp_word("antenna", {28'h0, ex}, {28'h0, got});
	endtask
	// Antenna order and one-tag flag, seen at each search request while ant_on is set
	always @(posedge pclk)
		if (search_req === 1'b1)
		begin
			n_req++;
			if (ant_on)
				cmp_ant(ant_q.size() ? ant_q.pop_front() : 4'hF, {search_one, ant_sel});
		end
	////////////////////////////////////////////////////////////////
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n == 50)
			miscompares++;
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic er;
		apb(1'b1, a, d, q, er);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] q);
		logic er;
		apb(1'b0, a, 32'h0, q, er);
	endtask
	task wait_idle;
		int n;
		n = 0;
		r = 32'h1;
		while (r[STAT_BUSY_BIT] !== 1'b0 && n < 300)
		begin
			rd(STATUS_OFS, r);
			n++;
		end
		cmp_word("idle", 32'h0, {31'h0, r[STAT_BUSY_BIT]});
	endtask
	task wait_resp;
		int n;
		n = 0;
		r = 32'h0;
		while (r[STAT_RESPV_BIT] !== 1'b1 && n < 300)
		begin
			rd(STATUS_OFS, r);
			n++;
		end
		rd(RESP_OFS, r);
	endtask
	// Stop, then make sure nothing new is started
	task stop_run;
		int n;
		wr(CTRL_OFS, 32'h0000_0002);
		// Drain while waiting: a full queue would hold the run in its push step
		n = 0;
		r = 32'h1;
		while ((r[STAT_BUSY_BIT] !== 1'b0 || r[STAT_RESPV_BIT] === 1'b1) && n < 300)
		begin
			rd(RESP_OFS, r);
			rd(STATUS_OFS, r);
			n++;
		end
		cmp_word("idle", 32'h0, {31'h0, r[STAT_BUSY_BIT]});
		n = n_req;
		repeat (30) @(posedge pclk);
		cmp_word("no_new_search", n, n_req);
	endtask
	task go(input seq_mode_t m, input logic [3:0] cnt, input logic [31:0] list,
		input logic [31:0] per, input logic [3:0] e8);
		int i, j;
		wr(PERIOD_OFS, per);
		wr(ANT_LIST_OFS, list);
		wr(STATUS_OFS, {28'h0, e8});
		ant_q.delete();
		for (i = 0; i < 60; i++)
		begin
			j = i % cnt;
			ant_q.push_back({m < MODE_MULTI_ONCE, j < 8 ? list[j*4 +: 3] : e8[2:0]});
		end
		t0 = tags_given;
		wr(CTRL_OFS, {20'h0, cnt, 2'b00, m, 3'b000, 1'b1});
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(STATUS_OFS, r);
		cmp_word("status_reset", 32'h0, r);
		rd(PERIOD_OFS, r);
		cmp_word("period_reset", PERIOD_RESET, r);
		apb(1'b0, 8'h14, 32'h0, r, e);
		cmp_word("unmapped_err", 32'h1, {31'h0, e});
		ant_on = 1;
		present <= 1'b1;
		k = n_req;
		go(MODE_SINGLE_ONCE, 4'h4, 32'h0000_1234, 32'h0, 4'h0);
		wait_idle();
		rd(RESP_OFS, r);
		cmp_word("so_resp", {8'h01, 8'h00, TAG_BASE + t0[15:0]}, r & MASK);
		cmp_word("so_searches", k + 1, n_req);
		rd(STATUS_OFS, r);
		cmp_word("so_single", 32'h0, r & 32'h7);
		present <= 1'b0;
		go(MODE_SINGLE_ONCE, 4'h9, 32'h4321_4321, 32'd40, 4'h2);
		wait_idle();
		rd(RESP_OFS, r);
		cmp_word("so_timeout", {24'h0, TAG_CNT_ZERO}, {24'h0, r[31:24]});
		go(MODE_SINGLE_ONCE, 4'h2, 32'h0000_0031, 32'h0, 4'h0);
		repeat (100) @(posedge pclk);
		rd(STATUS_OFS, r);
		cmp_word("so_no_period", 32'h1, r & 32'h5);
		stop_run();
		ant_on = 0;
		present <= 1'b1;
		go(MODE_SINGLE_REPEAT, 4'h4, 32'h0000_1234, 32'h0, 4'h0);
		for (k = 0; k < 3; k++)
		begin
			wait_resp();
			cmp_word("sr_resp", {8'h01, 8'h00, TAG_BASE + t0[15:0] + k[15:0]}, r & MASK);
		end
		stop_run();
		ant_on = 1;
		go(MODE_MULTI_ONCE, 4'h3, 32'h0000_0213, 32'd16, 4'h0);
		rd(STATUS_OFS, r);
		cmp_word("mo_early", 32'h1, r & 32'h5);
		wait_idle();
		rd(RESP_OFS, r);
		dt = tags_given - t0;
		cmp_word("mo_resp", {dt[7:0], 8'h00, TAG_BASE + t0[15:0] + dt[15:0] - 16'h1}, r & MASK);
		present <= 1'b0;
		go(MODE_MULTI_ONCE, 4'h1, 32'h0000_0004, 32'd16, 4'h0);
		wait_idle();
		rd(RESP_OFS, r);
		cmp_word("mo_empty", {24'h0, TAG_CNT_ZERO}, {24'h0, r[31:24]});
		ant_on = 0;
		present <= 1'b1;
		go(MODE_MULTI_REPEAT, 4'h2, 32'h0000_0014, 32'd16, 4'h0);
		for (k = 0; k < 2; k++)
		begin
			wait_resp();
			cmp_word("mr_count", 32'h1, {31'h0, r[31:24] != 8'h00});
		end
		present <= 1'b0;
		found = 1'b0;
		for (k = 0; k < 10 && !found; k++)
		begin
			wait_resp();
			found = (r[31:24] === TAG_CNT_ZERO);
		end
		cmp_word("mr_empty", 32'h1, {31'h0, found});
		stop_run();
		for (k = 0; k < 3; k++)
		begin
			go(MODE_SINGLE_ONCE, k == 0 ? 4'hA : 4'h1, k == 1 ? 32'h5 : 32'h0, 32'h0, 4'h0);
			rd(STATUS_OFS, r);
			cmp_word("bad_list", 32'h2, r & 32'h3);
		end
		report_and_stop();
	end
	initial
	begin
		#250000;
		miscompares++;
		report_and_stop();
	end
endmodule // tb_top
